// ===== brsalu_map.vh
// opcode, flag and register map constants for the rotate/subtract/skip alu
`ifndef BRSALU_MAP_VH
`define BRSALU_MAP_VH

// ----------------------------------------------------------------------------
// operation codes (5 bits)
// ----------------------------------------------------------------------------
`define BRSALU_OP_NONE        5'h00
`define BRSALU_OP_ROTL_C_ACC  5'h01
`define BRSALU_OP_ROTR        5'h02
`define BRSALU_OP_ROTR_ACC    5'h03
`define BRSALU_OP_ROTR_C      5'h04
`define BRSALU_OP_ROTR_C_ACC  5'h05
`define BRSALU_OP_SUB         5'h06
`define BRSALU_OP_SUB_MEM     5'h07
`define BRSALU_OP_SBC         5'h08
`define BRSALU_OP_SBC_MEM     5'h09
`define BRSALU_OP_DEC_SKZ     5'h0a
`define BRSALU_OP_DEC_SKZ_ACC 5'h0b
`define BRSALU_OP_INC_SKZ     5'h0c
`define BRSALU_OP_INC_SKZ_ACC 5'h0d
`define BRSALU_OP_SET         5'h0e
`define BRSALU_OP_SET_BIT     5'h0f
`define BRSALU_OP_SKNZ        5'h10
`define BRSALU_OP_SKNZ_BIT    5'h11
`define BRSALU_OP_SKZ         5'h12
`define BRSALU_OP_SWAP        5'h13
`define BRSALU_OP_SWAP_ACC    5'h14

// ----------------------------------------------------------------------------
// status field positions and reset values
// ----------------------------------------------------------------------------
`define BRSALU_FLG_C   0
`define BRSALU_FLG_AC  1
`define BRSALU_FLG_Z   2
`define BRSALU_FLG_OV  3
`define BRSALU_FLG_SC  4
`define BRSALU_FLG_CZ  5
`define BRSALU_FLAGS_RST 6'h00
`define BRSALU_ACC_RST   8'h00

// ----------------------------------------------------------------------------
// axi4-lite register byte addresses
// ----------------------------------------------------------------------------
`define BRSALU_REG_CMD    4'h0
`define BRSALU_REG_ACC    4'h4
`define BRSALU_REG_STATUS 4'h8
`define BRSALU_REG_RESULT 4'hc

// ----------------------------------------------------------------------------
// command register fields and timing
// ----------------------------------------------------------------------------
`define BRSALU_CMD_OP_LSB  0
`define BRSALU_CMD_BIT_LSB 8
`define BRSALU_CMD_OPD_LSB 16
`define BRSALU_SKIP_CYCLES 2'h2
`define BRSALU_RESP_OKAY   2'h0
`define BRSALU_RESP_SLVERR 2'h2

`endif

// ===== brsalu_core.v
// combinational execute datapath for the rotate/subtract/skip group
`timescale 1ns/1ns
`include "brsalu_map.vh"
module brsalu_core (
  // instruction
  input  wire [4:0] op,
  input  wire [7:0] opnd,
  input  wire [2:0] bit_sel,
  // architectural state in
  input  wire [7:0] acc,
  input  wire [5:0] flags,
  // results
  output reg  [7:0] res,
  output reg        wr_acc,
  output reg        wr_mem,
  output reg  [5:0] nxt_flags,
  output reg        skip,
  output reg        legal
);

  // --------------------------------------------------------------------------
  // subtract helper: acc - b - borrow, full flag set
  // --------------------------------------------------------------------------
  function [13:0] sub_f;
    input [7:0] a;
    input [7:0] b;
    input       bin;
    input       zold;
    reg   [8:0] d;
    reg   [4:0] lo;
    reg         ov;
    reg         z;
    reg         sc;
    begin
      d  = {1'b0, a} - {1'b0, b} - {8'h00, bin};
      lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
      ov = (a[7] ^ b[7]) & (a[7] ^ d[7]);
      z  = (d[7:0] == 8'h00);
      sc = ov ^ d[7];
      // cz chains zero across multi-byte borrow subtracts
      sub_f = {d[7:0], z & (bin ? zold : 1'b1), sc, ov, z, ~lo[4], ~d[8]};
    end
  endfunction

  reg [13:0] sr;
  reg [7:0]  mask;

  always @* begin
    res       = opnd;
    wr_acc    = 1'b0;
    wr_mem    = 1'b0;
    nxt_flags = flags;
    skip      = 1'b0;
    legal     = 1'b1;
    sr        = 14'h0000;
    mask      = 8'h01 << bit_sel;
    case (op)
      `BRSALU_OP_ROTL_C_ACC: begin
        res = {opnd[6:0], flags[`BRSALU_FLG_C]};
        wr_acc = 1'b1;
        nxt_flags[`BRSALU_FLG_C] = opnd[7];
      end
      `BRSALU_OP_ROTR: begin
        res = {opnd[0], opnd[7:1]};
        wr_mem = 1'b1;
      end
      `BRSALU_OP_ROTR_ACC: begin
        res = {opnd[0], opnd[7:1]};
        wr_acc = 1'b1;
      end
      `BRSALU_OP_ROTR_C, `BRSALU_OP_ROTR_C_ACC: begin
        res = {flags[`BRSALU_FLG_C], opnd[7:1]};
        wr_mem = (op == `BRSALU_OP_ROTR_C);
        wr_acc = (op == `BRSALU_OP_ROTR_C_ACC);
        nxt_flags[`BRSALU_FLG_C] = opnd[0];
      end
      `BRSALU_OP_SUB, `BRSALU_OP_SUB_MEM, `BRSALU_OP_SBC, `BRSALU_OP_SBC_MEM: begin
        // borrow-in is the inverted carry for the borrow forms
        sr = sub_f(acc, opnd,
                   ((op == `BRSALU_OP_SBC) | (op == `BRSALU_OP_SBC_MEM)) & ~flags[`BRSALU_FLG_C],
                   flags[`BRSALU_FLG_Z]);
        res = sr[13:6];
        nxt_flags = sr[5:0];
        wr_mem = (op == `BRSALU_OP_SUB_MEM) | (op == `BRSALU_OP_SBC_MEM);
        wr_acc = ~wr_mem;
      end
      `BRSALU_OP_DEC_SKZ, `BRSALU_OP_DEC_SKZ_ACC: begin
        res = opnd - 8'h01;
        wr_mem = (op == `BRSALU_OP_DEC_SKZ);
        wr_acc = (op == `BRSALU_OP_DEC_SKZ_ACC);
        skip = (res == 8'h00);
      end
      `BRSALU_OP_INC_SKZ, `BRSALU_OP_INC_SKZ_ACC: begin
        res = opnd + 8'h01;
        wr_mem = (op == `BRSALU_OP_INC_SKZ);
        wr_acc = (op == `BRSALU_OP_INC_SKZ_ACC);
        skip = (res == 8'h00);
      end
      `BRSALU_OP_SET: begin
        res = 8'hff;
        wr_mem = 1'b1;
      end
      `BRSALU_OP_SET_BIT: begin
        res = opnd | mask;
        wr_mem = 1'b1;
      end
      `BRSALU_OP_SKNZ: skip = (opnd != 8'h00);
      `BRSALU_OP_SKNZ_BIT: skip = ((opnd & mask) != 8'h00);
      `BRSALU_OP_SKZ: skip = (opnd == 8'h00);
      `BRSALU_OP_SWAP, `BRSALU_OP_SWAP_ACC: begin
        res = {opnd[3:0], opnd[7:4]};
        wr_mem = (op == `BRSALU_OP_SWAP);
        wr_acc = (op == `BRSALU_OP_SWAP_ACC);
      end
      `BRSALU_OP_NONE: legal = 1'b1;
      default: legal = 1'b0;
    endcase
  end

endmodule

// ===== brsalu_top.v
// rotate/subtract/skip alu top with axi4-lite register access
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "brsalu_map.vh"
module brsalu_top (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // sequencer issue
  input  wire        issue_valid,
  input  wire [4:0]  issue_op,
  input  wire [7:0]  issue_opnd,
  input  wire [2:0]  issue_bit,
  output wire        issue_ready,
  // sequencer feedback
  output reg         done_ff,
  output reg         skip_ff,
  output reg         dummy_ff,
  // data memory write-back
  output reg         mem_we_ff,
  output reg  [7:0]  mem_wdata_ff,
  // architectural state
  output reg  [7:0]  acc_ff,
  output reg  [5:0]  flags_ff,
  // axi4-lite write address
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  // --------------------------------------------------------------------------
  // sequencing states
  // --------------------------------------------------------------------------
  localparam ST_IDLE  = 2'b01;
  localparam ST_DUMMY = 2'b10;

  reg  [1:0] state_ff;
  reg  [1:0] nxt_state;
  reg        ill_ff;
  reg  [7:0] last_res_ff;

  // --------------------------------------------------------------------------
  // axi write path holding registers
  // --------------------------------------------------------------------------
  reg        aw_have_ff;
  reg  [3:0] aw_addr_ff;
  reg        w_have_ff;
  reg [31:0] w_data_ff;
  reg  [3:0] w_strb_ff;

  // --------------------------------------------------------------------------
  // command source: sequencer port or software command register
  // --------------------------------------------------------------------------
  wire       wr_fire  = aw_have_ff & w_have_ff & ~s_axi_bvalid;
  wire       sw_cmd   = wr_fire & (aw_addr_ff == `BRSALU_REG_CMD) & w_strb_ff[0];
  wire       can_exec = (state_ff == ST_IDLE);
  wire       hw_go    = issue_valid & can_exec;
  wire       sw_go    = sw_cmd & can_exec & ~issue_valid;
  wire       go       = hw_go | sw_go;
  wire [4:0] c_op     = hw_go ? issue_op   : w_data_ff[`BRSALU_CMD_OP_LSB +: 5];
  wire [7:0] c_opnd   = hw_go ? issue_opnd : w_data_ff[`BRSALU_CMD_OPD_LSB +: 8];
  wire [2:0] c_bit    = hw_go ? issue_bit  : w_data_ff[`BRSALU_CMD_BIT_LSB +: 3];

  // dummy slot blocks the sequencer while a skipped fetch is squashed
  assign issue_ready = can_exec;

  wire [7:0] res;
  wire       wr_acc;
  wire       wr_mem;
  wire [5:0] c_flags;
  wire       c_skip;
  wire       c_legal;

  brsalu_core u_core (
    .op        (c_op),
    .opnd      (c_opnd),
    .bit_sel   (c_bit),
    .acc       (acc_ff),
    .flags     (flags_ff),
    .res       (res),
    .wr_acc    (wr_acc),
    .wr_mem    (wr_mem),
    .nxt_flags (c_flags),
    .skip      (c_skip),
    .legal     (c_legal)
  );

  // --------------------------------------------------------------------------
  // next-state decode
  // --------------------------------------------------------------------------
  always @* begin
    case (state_ff)
      ST_IDLE:  nxt_state = (go & c_skip) ? ST_DUMMY : ST_IDLE;
      ST_DUMMY: nxt_state = ST_IDLE;
      default:  nxt_state = ST_IDLE;
    endcase
  end

  // --------------------------------------------------------------------------
  // execute and write-back
  // --------------------------------------------------------------------------
  wire acc_sw_wr = wr_fire & (aw_addr_ff == `BRSALU_REG_ACC) & w_strb_ff[0];
  wire flg_sw_wr = wr_fire & (aw_addr_ff == `BRSALU_REG_STATUS) & w_strb_ff[0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_ff     <= ST_IDLE;
      done_ff      <= 1'b0;
      skip_ff      <= 1'b0;
      dummy_ff     <= 1'b0;
      mem_we_ff    <= 1'b0;
      mem_wdata_ff <= 8'h00;
      acc_ff       <= `BRSALU_ACC_RST;
      flags_ff     <= `BRSALU_FLAGS_RST;
      ill_ff       <= 1'b0;
      last_res_ff  <= 8'h00;
    end else begin
      state_ff  <= nxt_state;
      done_ff   <= go;
      skip_ff   <= go & c_skip;
      dummy_ff  <= (state_ff == ST_DUMMY);
      mem_we_ff <= go & wr_mem & c_legal;
      if (go) begin
        mem_wdata_ff <= res;
        last_res_ff  <= res;
        ill_ff       <= ~c_legal;
      end
      // execution owns acc and flags over a software write in the same cycle
      if (go & wr_acc & c_legal) begin
        acc_ff <= res;
      end else if (acc_sw_wr) begin
        acc_ff <= w_data_ff[7:0];
      end
      if (go & c_legal) begin
        flags_ff <= c_flags;
      end else if (flg_sw_wr) begin
        flags_ff <= w_data_ff[5:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // axi4-lite write channel
  // --------------------------------------------------------------------------
  assign s_axi_awready = ~aw_have_ff;
  assign s_axi_wready  = ~w_have_ff;

  // a command write waits while the core is busy or the sequencer issues
  wire wr_stall = sw_cmd & ~sw_go;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff   <= 1'b0;
      aw_addr_ff   <= 4'h0;
      w_have_ff    <= 1'b0;
      w_data_ff    <= 32'h00000000;
      w_strb_ff    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `BRSALU_RESP_OKAY;
    end else begin
      if (s_axi_awvalid & ~aw_have_ff) begin
        aw_have_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid & ~w_have_ff) begin
        w_have_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (wr_fire & ~wr_stall) begin
        aw_have_ff   <= 1'b0;
        w_have_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_ff[1:0] != 2'h0) ? `BRSALU_RESP_SLVERR : `BRSALU_RESP_OKAY;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // axi4-lite read channel
  // --------------------------------------------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `BRSALU_RESP_OKAY;
    end else if (s_axi_arvalid & ~s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `BRSALU_RESP_OKAY;
      case (s_axi_araddr)
        `BRSALU_REG_CMD:    s_axi_rdata <= {30'h00000000, state_ff};
        `BRSALU_REG_ACC:    s_axi_rdata <= {24'h000000, acc_ff};
        `BRSALU_REG_STATUS: s_axi_rdata <= {26'h0000000, flags_ff};
        `BRSALU_REG_RESULT: s_axi_rdata <= {22'h000000, ill_ff, skip_ff, last_res_ff};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `BRSALU_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ===== brsalu_props.sv
// assertions on the rotate/subtract/skip alu top ports
`timescale 1ns/1ns
`include "brsalu_map.vh"
module brsalu_props (
  // clock and reset
  input wire       aclk,
  input wire       aresetn,
  // sequencer issue
  input wire       issue_valid,
  input wire [4:0] issue_op,
  input wire [7:0] issue_opnd,
  input wire       issue_ready,
  // results
  input wire       done_ff,
  input wire       skip_ff,
  input wire       dummy_ff,
  input wire       mem_we_ff,
  input wire [7:0] mem_wdata_ff,
  input wire [7:0] acc_ff,
  input wire [5:0] flags_ff
);
  // ------
  // helper
  // ------
  // operands of the op answered this cycle, so results tie to their cause
  reg [4:0] op_ff;
  reg [7:0] opnd_ff;
  reg [7:0] acc_q_ff;
  reg       c_q_ff;
  reg       took_ff;
  always @(posedge aclk) begin
    op_ff    <= issue_op;
    opnd_ff  <= issue_opnd;
    acc_q_ff <= acc_ff;
    c_q_ff   <= flags_ff[0];
    took_ff  <= issue_valid && issue_ready && aresetn;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_skip_taken; done_ff && skip_ff && !issue_ready; endsequence
  sequence s_dummy_slot; dummy_ff && issue_ready && !done_ff; endsequence
  // ----------
  // assertions
  // ----------
  a_skip_dummy_slot: assert property (skip_ff |-> s_skip_taken ##1 s_dummy_slot)
    else $error("skip without dummy slot");
  a_take_then_done: assert property (issue_valid && issue_ready |=> done_ff)
    else $error("op not answered next cycle");
  a_plain_no_dummy: assert property (done_ff && !skip_ff |=> !dummy_ff)
    else $error("dummy after plain op");
  a_rotl_acc_value: assert property (took_ff && op_ff == `BRSALU_OP_ROTL_C_ACC |->
    acc_ff == {opnd_ff[6:0], c_q_ff} && flags_ff[0] == opnd_ff[7] && !mem_we_ff) else $error("rotl wrong");
  a_rotr_mem_value: assert property (took_ff && op_ff == `BRSALU_OP_ROTR |->
    mem_we_ff && mem_wdata_ff == {opnd_ff[0], opnd_ff[7:1]} && $stable(flags_ff)) else $error("rotr wrong");
  a_sub_carry_flag: assert property (took_ff && op_ff == `BRSALU_OP_SUB |->
    flags_ff[0] == (acc_q_ff >= opnd_ff)) else $error("sub carry wrong");
  a_dec_skip_mem: assert property (took_ff && op_ff == `BRSALU_OP_DEC_SKZ |->
    mem_we_ff && mem_wdata_ff == opnd_ff - 8'h01 && skip_ff == (opnd_ff == 8'h01)) else $error("dec skip wrong");
  a_inc_skip_mem: assert property (took_ff && op_ff == `BRSALU_OP_INC_SKZ |->
    mem_we_ff && mem_wdata_ff == opnd_ff + 8'h01 && skip_ff == (opnd_ff == 8'hff)) else $error("inc skip wrong");
  a_set_byte_ones: assert property (took_ff && op_ff == `BRSALU_OP_SET |->
    mem_we_ff && mem_wdata_ff == 8'hff && $stable(flags_ff)) else $error("set wrong");
  a_skip_zero_test: assert property (took_ff && op_ff == `BRSALU_OP_SKZ |->
    skip_ff == (opnd_ff == 8'h00) && $stable(flags_ff) && !mem_we_ff) else $error("skip zero wrong");
  a_swap_acc_value: assert property (took_ff && op_ff == `BRSALU_OP_SWAP_ACC |->
    acc_ff == {opnd_ff[3:0], opnd_ff[7:4]} && !mem_we_ff) else $error("swap wrong");
endmodule
bind brsalu_top brsalu_props u_props (
  .aclk(aclk), .aresetn(aresetn), .issue_valid(issue_valid), .issue_op(issue_op),
  .issue_opnd(issue_opnd), .issue_ready(issue_ready), .done_ff(done_ff), .skip_ff(skip_ff),
  .dummy_ff(dummy_ff), .mem_we_ff(mem_we_ff), .mem_wdata_ff(mem_wdata_ff), .acc_ff(acc_ff),
  .flags_ff(flags_ff)
);

// ===== brsalu_mem_model.sv
// data memory byte behind the alu write-back port
`timescale 1ns/1ns
module brsalu_mem_model (
  // clock and reset
  input  wire       aclk,
  input  wire       aresetn,
  // write-back from the alu
  input  wire       mem_we_ff,
  input  wire [7:0] mem_wdata_ff,
  // addressed byte
  output reg  [7:0] mem_byte_ff
);
  // -------
  // storage
  // -------
  // changes only on a strobe, so a stray write from an acc form shows up
  always @(posedge aclk) begin
    if (!aresetn) begin
      mem_byte_ff <= 8'h00;
    end else if (mem_we_ff) begin
      mem_byte_ff <= mem_wdata_ff;
    end
  end
endmodule

// ===== byte_rotate_subtract_skip_alu_bench.sv
// self-checking bench for the rotate/subtract/skip alu
`timescale 1ns/1ns
`include "brsalu_map.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module byte_rotate_subtract_skip_alu_bench;
  // -------
  // signals
  // -------
  reg         aclk = 1'b0, aresetn = 1'b0, issue_valid = 1'b0;
  reg  [4:0]  issue_op = 5'h00;
  reg  [7:0]  issue_opnd = 8'h00;
  reg  [2:0]  issue_bit = 3'h0;
  reg  [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  reg  [31:0] s_axi_wdata = 32'h0;
  reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire        issue_ready, done_ff, skip_ff, dummy_ff, mem_we_ff;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [7:0]  mem_wdata_ff, acc_ff, mem_byte_ff;
  wire [5:0]  flags_ff;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int         err_total = 0, total_checks = 0, cyc = 0;
  reg  [1:0]  rsp;
  reg  [31:0] rd;
  always #5 aclk = ~aclk;
  brsalu_top dut (
    .aclk(aclk), .aresetn(aresetn), .issue_valid(issue_valid), .issue_op(issue_op),
    .issue_opnd(issue_opnd), .issue_bit(issue_bit), .issue_ready(issue_ready), .done_ff(done_ff),
    .skip_ff(skip_ff), .dummy_ff(dummy_ff), .mem_we_ff(mem_we_ff), .mem_wdata_ff(mem_wdata_ff),
    .acc_ff(acc_ff), .flags_ff(flags_ff), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );
  brsalu_mem_model u_mem (
    .aclk(aclk), .aresetn(aresetn), .mem_we_ff(mem_we_ff), .mem_wdata_ff(mem_wdata_ff),
    .mem_byte_ff(mem_byte_ff)
  );
  // -----
  // tasks
  // -----
  task end_of_test;
    begin
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
        $display("STATUS OK");
      end else begin
        $display("STATUS NOT OK");
      end
      $finish;
    end
  endtask
  // ceiling far above the roughly 130 cycles the sequence needs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      end_of_test;
    end
  end
  task axi_wr(input [3:0] a, input [31:0] d, input [1:0] er);
    reg aw_hs, w_hs, b_hs;
    begin
      b_hs = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!b_hs) begin
        @(negedge aclk);
        aw_hs = s_axi_awvalid && s_axi_awready;
        w_hs = s_axi_wvalid && s_axi_wready;
        b_hs = s_axi_bvalid && s_axi_bready;
        rsp = s_axi_bresp;
        @(posedge aclk);
        if (aw_hs) s_axi_awvalid <= 1'b0;
        if (w_hs) s_axi_wvalid <= 1'b0;
        if (b_hs) s_axi_bready <= 1'b0;
      end
      `CHK(rsp, er)
    end
  endtask
  task axi_rd(input [3:0] a);
    reg ar_hs, r_hs;
    begin
      r_hs = 1'b0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!r_hs) begin
        @(negedge aclk);
        ar_hs = s_axi_arvalid && s_axi_arready;
        r_hs = s_axi_rvalid && s_axi_rready;
        rd = s_axi_rdata;
        @(posedge aclk);
        if (ar_hs) s_axi_arvalid <= 1'b0;
        if (r_hs) s_axi_rready <= 1'b0;
      end
      `CHK(s_axi_rresp, `BRSALU_RESP_OKAY)
    end
  endtask
  // er is the result, ew a memory write, ea an acc write, es a skip
  task do_op(input [4:0] op, input [7:0] d, input [2:0] b, input [7:0] er, input ew, input ea, input es);
    reg [7:0] m0, a0;
    begin
      #1;
      m0 = mem_byte_ff;
      a0 = acc_ff;
      @(posedge aclk);
      issue_valid <= 1'b1;
      issue_op <= op;
      issue_opnd <= d;
      issue_bit <= b;
      @(posedge aclk);
      issue_valid <= 1'b0;
      #1;
      `CHK(done_ff, 1'b1)
      `CHK(skip_ff, es)
      `CHK(mem_we_ff, ew)
      `CHK(acc_ff, ea ? er : a0)
      if (ew) `CHK(mem_wdata_ff, er)
      @(posedge aclk);
      #1;
      `CHK(dummy_ff, es)
      `CHK(mem_byte_ff, ew ? er : m0)
    end
  endtask
  // --------
  // sequence
  // --------
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    axi_wr(`BRSALU_REG_STATUS, 32'h01, `BRSALU_RESP_OKAY);
    axi_wr(`BRSALU_REG_ACC, 32'h00, `BRSALU_RESP_OKAY);
    do_op(`BRSALU_OP_ROTL_C_ACC, 8'h81, 3'h0, 8'h03, 1'b0, 1'b1, 1'b0);
    `CHK(flags_ff, 6'h01)
    do_op(`BRSALU_OP_ROTR, 8'h01, 3'h0, 8'h80, 1'b1, 1'b0, 1'b0);
    do_op(`BRSALU_OP_ROTR_ACC, 8'h02, 3'h0, 8'h01, 1'b0, 1'b1, 1'b0);
    `CHK(flags_ff, 6'h01)
    do_op(`BRSALU_OP_ROTR_C, 8'h02, 3'h0, 8'h81, 1'b1, 1'b0, 1'b0);
    `CHK(flags_ff, 6'h00)
    do_op(`BRSALU_OP_ROTR_C_ACC, 8'h01, 3'h0, 8'h00, 1'b0, 1'b1, 1'b0);
    `CHK(flags_ff, 6'h01)
    axi_wr(`BRSALU_REG_ACC, 32'h05, `BRSALU_RESP_OKAY);
    do_op(`BRSALU_OP_SUB, 8'h06, 3'h0, 8'hff, 1'b0, 1'b1, 1'b0);
    `CHK(flags_ff, 6'h10)
    do_op(`BRSALU_OP_SUB_MEM, 8'h7f, 3'h0, 8'h80, 1'b1, 1'b0, 1'b0);
    `CHK(flags_ff, 6'h13)
    do_op(`BRSALU_OP_SBC, 8'hff, 3'h0, 8'h00, 1'b0, 1'b1, 1'b0);
    `CHK(flags_ff, 6'h27)
    axi_wr(`BRSALU_REG_STATUS, 32'h00, `BRSALU_RESP_OKAY);
    do_op(`BRSALU_OP_SBC_MEM, 8'h00, 3'h0, 8'hff, 1'b1, 1'b0, 1'b0);
    `CHK(flags_ff, 6'h10)
    axi_wr(`BRSALU_REG_ACC, 32'h80, `BRSALU_RESP_OKAY);
    do_op(`BRSALU_OP_SUB, 8'h01, 3'h0, 8'h7f, 1'b0, 1'b1, 1'b0);
    `CHK(flags_ff, 6'h19)
    do_op(`BRSALU_OP_DEC_SKZ, 8'h01, 3'h0, 8'h00, 1'b1, 1'b0, 1'b1);
    do_op(`BRSALU_OP_DEC_SKZ, 8'h00, 3'h0, 8'hff, 1'b1, 1'b0, 1'b0);
    do_op(`BRSALU_OP_DEC_SKZ_ACC, 8'h01, 3'h0, 8'h00, 1'b0, 1'b1, 1'b1);
    do_op(`BRSALU_OP_INC_SKZ_ACC, 8'h05, 3'h0, 8'h06, 1'b0, 1'b1, 1'b0);
    do_op(`BRSALU_OP_INC_SKZ, 8'hff, 3'h0, 8'h00, 1'b1, 1'b0, 1'b1);
    do_op(`BRSALU_OP_INC_SKZ, 8'h7f, 3'h0, 8'h80, 1'b1, 1'b0, 1'b0);
    do_op(`BRSALU_OP_SET, 8'h12, 3'h0, 8'hff, 1'b1, 1'b0, 1'b0);
    do_op(`BRSALU_OP_SET_BIT, 8'h00, 3'h5, 8'h20, 1'b1, 1'b0, 1'b0);
    do_op(`BRSALU_OP_SKNZ, 8'h00, 3'h0, 8'h00, 1'b0, 1'b0, 1'b0);
    do_op(`BRSALU_OP_SKNZ, 8'h40, 3'h0, 8'h00, 1'b0, 1'b0, 1'b1);
    do_op(`BRSALU_OP_SKNZ_BIT, 8'h40, 3'h6, 8'h00, 1'b0, 1'b0, 1'b1);
    do_op(`BRSALU_OP_SKNZ_BIT, 8'h40, 3'h5, 8'h00, 1'b0, 1'b0, 1'b0);
    do_op(`BRSALU_OP_SKZ, 8'h00, 3'h0, 8'h00, 1'b0, 1'b0, 1'b1);
    do_op(`BRSALU_OP_SKZ, 8'h01, 3'h0, 8'h00, 1'b0, 1'b0, 1'b0);
    `CHK(flags_ff, 6'h19)
    do_op(`BRSALU_OP_SWAP, 8'h3c, 3'h0, 8'hc3, 1'b1, 1'b0, 1'b0);
    do_op(`BRSALU_OP_SWAP_ACC, 8'ha5, 3'h0, 8'h5a, 1'b0, 1'b1, 1'b0);
    axi_rd(`BRSALU_REG_RESULT);
    `CHK(rd[9:0], 10'h05a)
    axi_rd(`BRSALU_REG_STATUS);
    `CHK(rd[5:0], 6'h19)
    axi_wr(`BRSALU_REG_CMD, 32'h0012_0014, `BRSALU_RESP_OKAY);
    axi_rd(`BRSALU_REG_ACC);
    `CHK(rd[7:0], 8'h21)
    // misaligned address is refused and must leave the accumulator alone
    axi_wr(4'h2, 32'h0000_00ee, `BRSALU_RESP_SLVERR);
    `CHK(acc_ff, 8'h21)
    // an undecoded opcode answers but changes nothing except the illegal bit and the result byte
    do_op(5'h1f, 8'h00, 3'h0, 8'h00, 1'b0, 1'b0, 1'b0);
    `CHK(flags_ff, 6'h19)
    axi_rd(`BRSALU_REG_RESULT);
    `CHK(rd[9:0], 10'h200)
    end_of_test;
  end
endmodule
